// [hdl/wdt_pkg.sv]
// constants shared by the watchdog timer control block
package wdt_pkg;
	localparam logic [11:0] WDT_CTRL_OFFS    = 12'h000;
	localparam logic [11:0] WDT_IRQ_STAT_OFFS = 12'h004;
	localparam logic [11:0] WDT_IRQ_MASK_OFFS = 12'h008;
	localparam logic [11:0] WDT_INSTR_OFFS   = 12'h00c;
	localparam int          WDT_PRE_MSB      = 7;
	localparam int          WDT_PRE_LSB      = 4;
	localparam int          WDT_IRS_BIT      = 3;
	localparam int          WDT_TSF_BIT      = 2;
	localparam int          WDT_EN_BIT       = 1;
	localparam int          WDT_WP_BIT       = 0;
	localparam logic [7:0]  WDT_CTRL_RST     = 8'h00;
	localparam logic [3:0]  WDT_PRE_IMM      = 4'h8;
	localparam int          WDT_CLK_HZ       = 50000000;
	localparam int          WDT_BASE_US      = 15625;
	localparam int          WDT_BASE_CYC     =
		(WDT_BASE_US * (WDT_CLK_HZ / 1000000));
	localparam int          WDT_TMO_NUM      = 8;
endpackage

// [hdl/wdt_tick.sv]
// divider giving one-cycle base tick pulses
`timescale 1ns/1ns
module wdt_tick
	import wdt_pkg::*;
#(
	parameter int BASE_CYC = WDT_BASE_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic restart,
	output logic      tick
);
	initial begin
		if (BASE_CYC < 1) $error("base count must be positive");
	end
	logic [31:0] cnt_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (restart) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_q == 32'(BASE_CYC - 1)) begin
			cnt_q <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule

// [hdl/wdt_period.sv]
// counts base ticks up to the selected period
`timescale 1ns/1ns
module wdt_period
	import wdt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       restart,
	input  wire logic       tick,
	input  wire logic [3:0] presc,
	output logic            expired
);
	logic [7:0] ticks_q;
	logic [7:0] limit;
	// code n lasts 2^n base ticks; codes 0..7 only
	assign limit = 8'(8'h1 << presc[2:0]);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ticks_q <= 8'h0;
			expired <= 1'b0;
		end else if (restart) begin
			ticks_q <= 8'h0;
			expired <= 1'b0;
		end else if (tick) begin
			if (ticks_q == limit - 8'h1) begin
				ticks_q <= 8'h0;
				expired <= 1'b1;
			end else begin
				ticks_q <= ticks_q + 8'h1;
				expired <= 1'b0;
			end
		end else begin
			expired <= 1'b0;
		end
	end
endmodule

// [hdl/wdt_ctrl.sv]
// watchdog timer control with its register and apb slave
//
// Functional notes
// - code 1000 resets at once; 0110/0111 are 1000/2000 ms; above reserved
// - bit 3 set: expiry raises an interrupt instead of a reset
// - the watchdog interrupt ignores the global interrupt enable
// - the watchdog interrupt always uses the fixed high priority level
// - every timeout sets the status flag at bit 2
// - status flag clears by writing zero or hardware reset only
// - writing one to enable bit 1 enables and restarts the counters
// - without refresh before the period ends, reset or interrupt follows
// - enable clears on zero write, watchdog reset, hardware reset, supply
// - control write works only right after the write-permission bit set
// - writing 72h enables the watchdog with a 2.0 s period
`timescale 1ns/1ns
module wdt_ctrl
	import wdt_pkg::*;
#(
	parameter int BASE_CYC = WDT_BASE_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        supplyMonitorIrq,
	output logic             dogReset,
	output logic             dogIrq,
	output logic             dogIrqHighPrio,
	output logic             irq
);
	initial begin
		if (BASE_CYC < 1) $error("base count must be positive");
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode
	logic       acc;
	logic       wrCtrl;
	logic       wrStat;
	logic       wrMask;
	logic       wrInstr;
	logic [7:0] wdata;
	assign acc   = psel & penable & pready;
	assign wdata = pwdata[7:0];
	always_comb begin
		wrCtrl  = 1'b0;
		wrStat  = 1'b0;
		wrMask  = 1'b0;
		wrInstr = 1'b0;
		if (acc && pwrite && paddr == WDT_CTRL_OFFS) begin
			wrCtrl = 1'b1;
		end else if (acc && pwrite && paddr == WDT_IRQ_STAT_OFFS) begin
			wrStat = 1'b1;
		end else if (acc && pwrite && paddr == WDT_IRQ_MASK_OFFS) begin
			wrMask = 1'b1;
		end else if (acc && pwrite && paddr == WDT_INSTR_OFFS) begin
			wrInstr = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register
	logic [3:0] presc_q;
	logic       irqSel_q;
	logic       tsf_q;
	logic       en_q;
	logic       wp_q;
	logic       wpSet;
	logic       immCode;
	logic       rstEvt;
	logic       irqEvt;
	logic       allowed;
	logic       expired;
	logic       immReset;
	logic       restart;
	logic       tick;
	logic       timeout;
	logic       instrDone;
	// any bus access counts as the instruction after the permission step
	assign instrDone = acc;
	assign wpSet     = wrCtrl & wdata[WDT_WP_BIT] & ~wp_q;
	assign allowed   = wrCtrl & wp_q;
	assign restart   = (allowed & wdata[WDT_EN_BIT]) | ~en_q;
	assign immCode   = (presc_q == WDT_PRE_IMM);
	assign immReset  = en_q & immCode;
	assign timeout   = en_q & (expired | immCode);
	// code 1000 always resets, whatever the response select says
	assign rstEvt    = timeout & (~irqSel_q | immCode);
	assign irqEvt    = timeout & irqSel_q & ~immCode;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_q <= WDT_CTRL_RST[WDT_WP_BIT];
		end else if (wpSet) begin
			wp_q <= 1'b1;
		end else if (wp_q && instrDone) begin
			wp_q <= 1'b0;
		end else if (wrInstr) begin
			wp_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_q  <= WDT_CTRL_RST[WDT_PRE_MSB:WDT_PRE_LSB];
			irqSel_q <= WDT_CTRL_RST[WDT_IRS_BIT];
		end else if (allowed) begin
			presc_q  <= wdata[WDT_PRE_MSB:WDT_PRE_LSB];
			irqSel_q <= wdata[WDT_IRS_BIT];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_q <= WDT_CTRL_RST[WDT_EN_BIT];
		end else if (supplyMonitorIrq) begin
			en_q <= 1'b0;
		end else if (rstEvt) begin
			en_q <= 1'b0;
		end else if (allowed) begin
			en_q <= wdata[WDT_EN_BIT];
		end
	end

	// set wins over a clearing write in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tsf_q <= WDT_CTRL_RST[WDT_TSF_BIT];
		end else if (timeout) begin
			tsf_q <= 1'b1;
		end else if (allowed && !wdata[WDT_TSF_BIT]) begin
			tsf_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timebase
	wdt_tick #(
		.BASE_CYC(BASE_CYC)
	) u_tick (
		.clk    (clk),
		.sys_rst(sys_rst),
		.restart(restart),
		.tick   (tick)
	);

	wdt_period u_period (
		.clk    (clk),
		.sys_rst(sys_rst),
		.restart(restart),
		.tick   (tick),
		.presc  (presc_q),
		.expired(expired)
	);

	////////////////////////////////////////////////////////////////////////
	// response outputs
	// the watchdog interrupt bypasses the global enable, so no gate here
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dogReset       <= 1'b0;
			dogIrq         <= 1'b0;
			dogIrqHighPrio <= 1'b0;
		end else begin
			dogReset       <= rstEvt;
			dogIrq         <= irqEvt;
			dogIrqHighPrio <= irqEvt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status and mask
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [1:0] evt;
	assign evt = {rstEvt, irqEvt};
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_q <= 2'h0;
		end else if (wrStat) begin
			stat_q <= (stat_q & ~wdata[1:0]) | evt;
		end else begin
			stat_q <= stat_q | evt;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_q <= 2'h0;
		end else if (wrMask) begin
			mask_q <= wdata[1:0];
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb read path, no wait states
	logic [7:0] ctrlRd;
	assign ctrlRd = {presc_q, irqSel_q, tsf_q, en_q, wp_q};
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (paddr == WDT_CTRL_OFFS) begin
				prdata <= {24'h0, ctrlRd};
			end else if (paddr == WDT_IRQ_STAT_OFFS) begin
				prdata <= {30'h0, stat_q};
			end else if (paddr == WDT_IRQ_MASK_OFFS) begin
				prdata <= {30'h0, mask_q};
			end else if (paddr == WDT_INSTR_OFFS) begin
				prdata <= 32'h0;
			end else begin
				pslverr <= 1'b1;
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_permit;
		wpSet;
	endsequence
	sequence s_next_acc;
		##[1:20] acc;
	endsequence

	a_timeout_flag: assert property (@(posedge clk) disable iff (sys_rst)
		timeout |=> tsf_q)
		else $error("status flag not set on timeout");
	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(tsf_q) |-> $past(allowed))
		else $error("status flag cleared without write");
	a_irq_choice: assert property (@(posedge clk) disable iff (sys_rst)
		(timeout && irqSel_q && presc_q != WDT_PRE_IMM) |=>
		(dogIrq && !dogReset))
		else $error("interrupt response not taken");
	a_reset_choice: assert property (@(posedge clk) disable iff (sys_rst)
		(timeout && (!irqSel_q || presc_q == WDT_PRE_IMM)) |=>
		(dogReset && !dogIrq && !en_q))
		else $error("reset response not taken");
	a_imm_reset: assert property (@(posedge clk) disable iff (sys_rst)
		immReset |=> dogReset)
		else $error("code 1000 did not reset at once");
	a_prio_fixed: assert property (@(posedge clk) disable iff (sys_rst)
		dogIrq == dogIrqHighPrio)
		else $error("interrupt priority not high");
	a_write_guard: assert property (@(posedge clk) disable iff (sys_rst)
		(wrCtrl && !wp_q && !wdata[WDT_WP_BIT]) |=>
		$stable(presc_q) && $stable(irqSel_q))
		else $error("unprotected write took effect");
	a_permit_once: assert property (@(posedge clk) disable iff (sys_rst)
		s_permit ##1 (wp_q throughout s_next_acc) |=> !wp_q)
		else $error("write permission outlived next access");
	a_supply_off: assert property (@(posedge clk) disable iff (sys_rst)
		supplyMonitorIrq |=> !en_q)
		else $error("enable kept after supply event");
	a_enable_write: assert property (@(posedge clk) disable iff (sys_rst)
		(allowed && wdata[WDT_EN_BIT] && !supplyMonitorIrq) |=> en_q)
		else $error("enable write ignored");
	a_load_72: assert property (@(posedge clk) disable iff (sys_rst)
		(allowed && wdata == 8'h72 && !supplyMonitorIrq) |=>
		(presc_q == 4'h7 && en_q && !irqSel_q))
		else $error("72h did not set 2 s enable");
endmodule

// [verification/tb_watchdog_timer_control.sv]
// self-checking bench for the watchdog timer control block
`timescale 1ns/1ns
module tb_watchdog_timer_control import wdt_pkg::*; ;
	// a short base tick keeps the 2000 ms period at 512 cycles
	localparam int BC = 4;
	logic        clk = 1'b0;
	logic        sysRst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        smIrq;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        lastErr;
	logic        dogReset;
	logic        dogIrq;
	logic        dogIrqHighPrio;
	logic        irq;
	int          fails;
	int          checks;
	int          cyc;
	int          nRst;
	int          nIrq;
	int          took;
	int          n0;

	wdt_ctrl #(.BASE_CYC(BC)) dut (
		.clk             (clk),
		.sys_rst         (sysRst),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.paddr           (paddr),
		.pwdata          (pwdata),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.supplyMonitorIrq(smIrq),
		.dogReset        (dogReset),
		.dogIrq          (dogIrq),
		.dogIrqHighPrio  (dogIrqHighPrio),
		.irq             (irq)
	);

	always #10 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	// the request stands until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		while (!ok && n < 20) begin
			@(posedge clk);
			ok = (pready === 1'b1);
			n++;
		end
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, ok}, 32'h1);
	endtask

	task automatic pw(input logic [31:0] d);
		apb(1'b1, WDT_CTRL_OFFS, 32'h1);
		apb(1'b1, WDT_CTRL_OFFS, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic waitEv(input bit isIrq, input int lim);
		int c0;
		c0 = isIrq ? nIrq : nRst;
		took = 0;
		while ((isIrq ? nIrq : nRst) == c0 && took < lim) begin
			@(negedge clk);
			took++;
		end
		chk({31'h0, took < lim}, 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(negedge clk) begin
		if (dogReset === 1'b1) nRst++;
		if (dogIrq === 1'b1) nIrq++;
		if (dogIrq === 1'b1 || dogIrqHighPrio === 1'b1)
			chk({31'h0, dogIrqHighPrio}, {31'h0, dogIrq});
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		sysRst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		smIrq = 1'b0;
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;
		rdc(WDT_CTRL_OFFS, 32'h0);
		rdc(12'h010, 32'h0);
		chk({31'h0, lastErr}, 32'h1);
		apb(1'b1, WDT_CTRL_OFFS, 32'h42);
		rdc(WDT_CTRL_OFFS, 32'h0);
		apb(1'b1, WDT_CTRL_OFFS, 32'h1);
		apb(1'b1, WDT_INSTR_OFFS, 32'h0);
		apb(1'b1, WDT_CTRL_OFFS, 32'h42);
		rdc(WDT_CTRL_OFFS, 32'h0);
		pw(32'h72);
		rdc(WDT_CTRL_OFFS, 32'h72);
		for (int c = 6; c < 8; c++) begin
			pw({24'h0, c[3:0], 4'h2});
			waitEv(1'b0, 1200);
			chk({31'h0, took >= (BC << c) - 4 && took <= (BC << c) + 4},
				32'h1);
			rdc(WDT_CTRL_OFFS, {24'h0, c[3:0], 4'h4});
		end
		pw(32'h42);
		n0 = nRst;
		repeat (6) begin
			repeat (30) @(posedge clk);
			pw(32'h42);
		end
		chk(nRst, n0);
		waitEv(1'b0, 100);
		rdc(WDT_CTRL_OFFS, 32'h44);
		rdc(WDT_IRQ_STAT_OFFS, 32'h2);
		apb(1'b1, WDT_IRQ_STAT_OFFS, 32'h2);
		rdc(WDT_IRQ_STAT_OFFS, 32'h0);
		// interrupt response: raised, masked, cleared
		apb(1'b1, WDT_IRQ_MASK_OFFS, 32'h1);
		pw(32'h4a);
		n0 = nRst;
		waitEv(1'b1, 100);
		chk(nRst, n0);
		rdc(WDT_CTRL_OFFS, 32'h4e);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, WDT_IRQ_MASK_OFFS, 32'h0);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, WDT_IRQ_MASK_OFFS, 32'h1);
		pw(32'h08);
		rdc(WDT_CTRL_OFFS, 32'h08);
		apb(1'b1, WDT_IRQ_STAT_OFFS, 32'h1);
		rdc(WDT_IRQ_STAT_OFFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		pw(32'h82);
		waitEv(1'b0, 10);
		rdc(WDT_CTRL_OFFS, 32'h84);
		n0 = nIrq;
		pw(32'h8a);
		waitEv(1'b0, 10);
		chk(nIrq, n0);
		rdc(WDT_CTRL_OFFS, 32'h8c);
		pw(32'h42);
		@(posedge clk);
		smIrq <= 1'b1;
		@(posedge clk);
		smIrq <= 1'b0;
		rdc(WDT_CTRL_OFFS, 32'h40);
		n0 = nRst;
		repeat (100) @(posedge clk);
		chk(nRst, n0);
		close_out();
	end
endmodule
